// >>> jtid_pkg.sv
package jtid_pkg;
   // ======================================================
   // register sizes
   localparam int IR_W = 8;
   localparam int ID_W = 32;
   localparam int BSR_LEN = 113;
   localparam int BSR_OUTS = 40;
   localparam int SYNC_STAGES = 2;
   // ======================================================
   // instruction codes
   localparam logic [7:0] IR_EXTEST = 8'h00;
   localparam logic [7:0] IR_IDCODE = 8'h21;
   localparam logic [7:0] IR_SAMPLE = 8'h05;
   localparam logic [7:0] IR_CLAMP = 8'h07;
   localparam logic [7:0] IR_HIGHZ = 8'h03;
   localparam logic [7:0] IR_BYPASS = 8'hFF;
   localparam logic [7:0] IR_CAPTURE_VAL = 8'h01;
   // ======================================================
   // identification word layout
   localparam int ID_REV_MSB = 31;
   localparam int ID_REV_LSB = 28;
   localparam int ID_DEV_MSB = 27;
   localparam int ID_DEV_LSB = 12;
   localparam int ID_MAKER_MSB = 11;
   localparam int ID_MAKER_LSB = 1;
   localparam int ID_PRESENT_BIT = 0;
   localparam logic ID_PRESENT_VAL = 1'h1;
   // ======================================================
   // types
   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
      TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
      TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
   } jtid_tap_state_t;
   typedef enum logic [1:0] {SEL_BSR, SEL_BYP, SEL_ID} jtid_dr_sel_t;
   typedef struct packed {
      logic clamp;
      logic highz;
   } jtid_pinmode_t;
   typedef struct packed {
      logic tms;
      logic tdi;
   } jtid_tap_in_t;
endpackage : jtid_pkg

// >>> jtid_sync.sv
module jtid_sync #(
   parameter int W = 1
) (
   // clock and reset of the receiving side
   input wire logic clk_i,
   input wire logic rst_n_i,
   // data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   // ======================================================
   // two-flop level crossing
   logic [W-1:0] meta_ff;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_ff <= '0;
         q_o <= '0;
      end else begin
         meta_ff <= d_i;
         q_o <= meta_ff;
      end
   end
endmodule : jtid_sync

// >>> jtid_tap.sv
module jtid_tap
   import jtid_pkg::*;
#(
   parameter int N_BSR = BSR_LEN,
   parameter int N_OUT = BSR_OUTS,
   parameter logic [3:0] ID_REV = 4'h1,        // arbitrary value
   parameter logic [15:0] ID_DEV = 16'h0001,   // arbitrary value
   parameter logic [10:0] ID_MAKER = 11'h001   // arbitrary value
) (
   // system clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RST_N_I,
   // test port
   input wire logic TCK_I,
   input wire jtid_tap_in_t TAP_I,
   output logic TDO_O,
   output logic TDO_OE_N_O,
   // core side
   input wire logic [N_OUT-1:0] CORE_OUT_I,
   input wire logic [N_OUT-1:0] CORE_OE_N_I,
   // pins
   input wire logic [N_BSR-N_OUT-1:0] PIN_IN_I,
   output logic [N_OUT-1:0] PIN_OUT_O,
   output logic [N_OUT-1:0] PIN_OE_N_O
);
   localparam int N_IN = N_BSR - N_OUT;
   localparam logic [ID_W-1:0] ID_WORD = {ID_REV, ID_DEV, ID_MAKER, ID_PRESENT_VAL};

   jtid_tap_state_t state_ff, nxt_state;
   logic [IR_W-1:0] ir_sh_ff, ir_ff;
   logic byp_ff;
   logic [ID_W-1:0] id_sh_ff;
   logic [N_BSR-1:0] bsr_sh_ff, bsr_upd_ff;
   logic upd_tgl_ff;
   jtid_dr_sel_t dr_sel;
   jtid_pinmode_t mode, mode_ff, sys_mode;
   logic [N_IN-1:0] in_samp;
   logic [N_OUT-1:0] out_samp;
   logic sys_tgl, sys_tgl_d_ff;
   jtid_pinmode_t sys_mode_d_ff, pin_mode_ff;
   logic [N_OUT-1:0] hold_ff;
   logic tms, tdi;

   assign tms = TAP_I.tms;
   assign tdi = TAP_I.tdi;

   // ======================================================
   // test controller state machine
   always_comb begin
      case (state_ff)
         TAP_RESET: nxt_state = tms ? TAP_RESET : TAP_IDLE;
         TAP_IDLE: nxt_state = tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: nxt_state = tms ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: nxt_state = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_SHIFT_DR: nxt_state = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_EXIT1_DR: nxt_state = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
         TAP_PAUSE_DR: nxt_state = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
         TAP_EXIT2_DR: nxt_state = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
         TAP_UPD_DR: nxt_state = tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: nxt_state = tms ? TAP_RESET : TAP_CAP_IR;
         TAP_CAP_IR: nxt_state = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_SHIFT_IR: nxt_state = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_EXIT1_IR: nxt_state = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
         TAP_PAUSE_IR: nxt_state = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
         TAP_EXIT2_IR: nxt_state = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
         TAP_UPD_IR: nxt_state = tms ? TAP_SEL_DR : TAP_IDLE;
         default: nxt_state = TAP_RESET;
      endcase
   end

   always_ff @(posedge TCK_I or negedge RST_N_I) begin
      if (!RST_N_I) state_ff <= TAP_RESET;
      else state_ff <= nxt_state;
   end

   // ======================================================
   // instruction register
   always_ff @(posedge TCK_I or negedge RST_N_I) begin
      if (!RST_N_I) ir_sh_ff <= IR_CAPTURE_VAL;
      else if (state_ff == TAP_CAP_IR) ir_sh_ff <= IR_CAPTURE_VAL;
      else if (state_ff == TAP_SHIFT_IR) ir_sh_ff <= {tdi, ir_sh_ff[IR_W-1:1]};
   end

   always_ff @(posedge TCK_I or negedge RST_N_I) begin
      if (!RST_N_I) ir_ff <= IR_IDCODE;
      else if (state_ff == TAP_RESET) ir_ff <= IR_IDCODE;
      else if (state_ff == TAP_UPD_IR) ir_ff <= ir_sh_ff;
   end

   // ======================================================
   // decode; only clamp and high-z touch the pins
   always_comb begin
      mode = '0;
      case (ir_ff)
         IR_EXTEST: dr_sel = SEL_BSR;
         IR_SAMPLE: dr_sel = SEL_BSR;
         IR_IDCODE: dr_sel = SEL_ID;
         IR_BYPASS: dr_sel = SEL_BYP;
         IR_CLAMP: begin
            dr_sel = SEL_BYP;
            mode.clamp = 1'b1;
         end
         IR_HIGHZ: begin
            dr_sel = SEL_BYP;
            mode.highz = 1'b1;
         end
         default: dr_sel = SEL_BYP;
      endcase
   end

   always_ff @(posedge TCK_I or negedge RST_N_I) begin
      if (!RST_N_I) mode_ff <= '0;
      else mode_ff <= mode;
   end

   // ======================================================
   // data registers
   always_ff @(posedge TCK_I or negedge RST_N_I) begin
      if (!RST_N_I) byp_ff <= 1'b0;
      else if (state_ff == TAP_CAP_DR) byp_ff <= 1'b0;
      else if (state_ff == TAP_SHIFT_DR) byp_ff <= tdi;
   end

   always_ff @(posedge TCK_I or negedge RST_N_I) begin
      if (!RST_N_I) id_sh_ff <= '0;
      else if (state_ff == TAP_CAP_DR && dr_sel == SEL_ID) id_sh_ff <= ID_WORD;
      else if (state_ff == TAP_SHIFT_DR && dr_sel == SEL_ID)
         id_sh_ff <= {tdi, id_sh_ff[ID_W-1:1]};
   end

   // pin samples cross in; a moving pin may read either way
   jtid_sync #(.W(N_IN)) u_in_sync (
      .clk_i(TCK_I),
      .rst_n_i(RST_N_I),
      .d_i(PIN_IN_I),
      .q_o(in_samp)
   );
   jtid_sync #(.W(N_OUT)) u_out_sync (
      .clk_i(TCK_I),
      .rst_n_i(RST_N_I),
      .d_i(PIN_OUT_O),
      .q_o(out_samp)
   );

   always_ff @(posedge TCK_I or negedge RST_N_I) begin
      if (!RST_N_I) bsr_sh_ff <= '0;
      else if (state_ff == TAP_CAP_DR && dr_sel == SEL_BSR)
         bsr_sh_ff <= {out_samp, in_samp};
      else if (state_ff == TAP_SHIFT_DR && dr_sel == SEL_BSR)
         bsr_sh_ff <= {tdi, bsr_sh_ff[N_BSR-1:1]};
   end

   // update word is held still until the next toggle, so the
   // system side may copy it once the toggle has crossed
   always_ff @(posedge TCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         bsr_upd_ff <= '0;
         upd_tgl_ff <= 1'b0;
      end else if (state_ff == TAP_UPD_DR && dr_sel == SEL_BSR) begin
         bsr_upd_ff <= bsr_sh_ff;
         upd_tgl_ff <= ~upd_tgl_ff;
      end
   end

   // ======================================================
   // serial out on the falling edge
   always_ff @(negedge TCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         TDO_O <= 1'b0;
         TDO_OE_N_O <= 1'b1;
      end else begin
         TDO_OE_N_O <= !(state_ff == TAP_SHIFT_DR || state_ff == TAP_SHIFT_IR);
         if (state_ff == TAP_SHIFT_IR) TDO_O <= ir_sh_ff[0];
         else if (dr_sel == SEL_ID) TDO_O <= id_sh_ff[0];
         else if (dr_sel == SEL_BSR) TDO_O <= bsr_sh_ff[0];
         else TDO_O <= byp_ff;
      end
   end

   // ======================================================
   // system domain: pin drive
   jtid_sync #(.W(3)) u_ctl_sync (
      .clk_i(SYS_CLK_I),
      .rst_n_i(RST_N_I),
      .d_i({mode_ff, upd_tgl_ff}),
      .q_o({sys_mode, sys_tgl})
   );

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         sys_tgl_d_ff <= 1'b0;
         hold_ff <= '0;
      end else begin
         sys_tgl_d_ff <= sys_tgl;
         if (sys_tgl != sys_tgl_d_ff) hold_ff <= bsr_upd_ff[N_BSR-1:N_IN];
      end
   end

   // mode bits flip on one edge but may cross a cycle apart;
   // take a mode only after two equal reads, no mixed-mode blip
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         sys_mode_d_ff <= '0;
         pin_mode_ff <= '0;
      end else begin
         sys_mode_d_ff <= sys_mode;
         if (sys_mode == sys_mode_d_ff) pin_mode_ff <= sys_mode;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         PIN_OUT_O <= '0;
         PIN_OE_N_O <= '1;
      end else begin
         PIN_OUT_O <= pin_mode_ff.clamp ? hold_ff : CORE_OUT_I;
         PIN_OE_N_O <= pin_mode_ff.highz ? '1 : CORE_OE_N_I;
      end
   end

   // ======================================================
   // checks
   sequence s_cap_id;
      state_ff == TAP_CAP_DR && dr_sel == SEL_ID;
   endsequence
   sequence s_cap_bsr;
      state_ff == TAP_CAP_DR && dr_sel == SEL_BSR;
   endsequence

   a_id_lsb_one: assert property (@(posedge TCK_I) disable iff (!RST_N_I)
      s_cap_id |=> id_sh_ff[ID_PRESENT_BIT] == ID_PRESENT_VAL)
      else $error("id presence bit not one");
   a_id_field_layout: assert property (@(posedge TCK_I) disable iff (!RST_N_I)
      s_cap_id |=> id_sh_ff[ID_REV_MSB:ID_REV_LSB] == ID_REV
      && id_sh_ff[ID_DEV_MSB:ID_DEV_LSB] == ID_DEV
      && id_sh_ff[ID_MAKER_MSB:ID_MAKER_LSB] == ID_MAKER)
      else $error("id field layout wrong");
   a_id_shift_out: assert property (@(posedge TCK_I) disable iff (!RST_N_I)
      s_cap_id ##1 state_ff == TAP_SHIFT_DR |=> id_sh_ff[ID_W-2:0] == ID_WORD[ID_W-1:1])
      else $error("id word not shifted");
   a_tlr_selects_id: assert property (@(posedge TCK_I) disable iff (!RST_N_I)
      state_ff == TAP_RESET |=> ir_ff == IR_IDCODE && dr_sel == SEL_ID)
      else $error("reset did not select id");
   a_ir_update_only: assert property (@(posedge TCK_I) disable iff (!RST_N_I)
      state_ff != TAP_UPD_IR && state_ff != TAP_RESET |=> $stable(ir_ff))
      else $error("instruction changed outside update");
   a_ir_update_load: assert property (@(posedge TCK_I) disable iff (!RST_N_I)
      state_ff == TAP_UPD_IR |=> ir_ff == $past(ir_sh_ff))
      else $error("instruction not applied at update");
   a_bsr_capture: assert property (@(posedge TCK_I) disable iff (!RST_N_I)
      s_cap_bsr |=> bsr_sh_ff == $past({out_samp, in_samp}))
      else $error("boundary cells not captured");
   a_sample_path: assert property (@(posedge TCK_I) disable iff (!RST_N_I)
      ir_ff == IR_SAMPLE || ir_ff == IR_EXTEST |-> dr_sel == SEL_BSR)
      else $error("boundary register not in path");
   a_bypass_path: assert property (@(posedge TCK_I) disable iff (!RST_N_I)
      ir_ff != IR_EXTEST && ir_ff != IR_SAMPLE && ir_ff != IR_IDCODE
      && state_ff == TAP_SHIFT_DR |=> byp_ff == $past(tdi) && dr_sel == SEL_BYP)
      else $error("bypass not in path");
   a_pin_mode_decode: assert property (@(posedge TCK_I) disable iff (!RST_N_I)
      1'b1 |=> mode_ff.clamp == ($past(ir_ff) == IR_CLAMP)
      && mode_ff.highz == ($past(ir_ff) == IR_HIGHZ))
      else $error("pin mode decode wrong");
   a_highz_force: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      pin_mode_ff.highz |=> PIN_OE_N_O == '1)
      else $error("outputs not released");
   a_normal_ops: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      !pin_mode_ff.clamp && !pin_mode_ff.highz
      |=> PIN_OUT_O == $past(CORE_OUT_I) && PIN_OE_N_O == $past(CORE_OE_N_I))
      else $error("normal pin operation disturbed");
endmodule : jtid_tap

// >>> jtid_ctl_model.sv
// ======================================================
// test controller model: drives mode select and data in
module jtid_ctl_model
   import jtid_pkg::*;
(
   // test clock and serial return
   input wire logic tck_i,
   input wire logic tdo_i,
   input wire logic tdo_oe_n_i,
   // mode select and data in
   output jtid_tap_in_t tap_o
);
   timeunit 1ns;
   timeprecision 100ps;

   initial tap_o = '{tms: 1'b1, tdi: 1'b0};

   // one controller step; signals move just after the rising edge
   task automatic step(input logic tms);
      tap_o.tms = tms;
      @(posedge tck_i);
      #1;
   endtask : step

   // five ones reach test-logic-reset from any state, then park in idle
   task automatic go_idle();
      repeat (5) step(1'b1);
      step(1'b0);
   endtask : go_idle

   // one scan from idle; codes come from the bench's table and from the direct IR_BYPASS load at the end
   task automatic scan(input logic ir, input int n, input logic [159:0] din,
                       output logic [159:0] dout);
      dout = '0;
      step(1'b1);
      if (ir) begin
         step(1'b1);
      end
      step(1'b0);
      step(1'b0);
      for (int i = 0; i < n; i++) begin
         tap_o.tdi = din[i];
         tap_o.tms = (i == n - 1);
         @(posedge tck_i);
         // a released data out must not pass as a bit
         dout[i] = tdo_oe_n_i ? 1'bx : tdo_i;
         #1;
      end
      // released data in shows the inverse, not the last bit
      tap_o.tdi = ~tap_o.tdi;
      step(1'b1);
      step(1'b0);
   endtask : scan
endmodule : jtid_ctl_model

// >>> testbench.sv
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
   $display("[FAIL] %0t %s", $time, m); end end
// ======================================================
// bench top
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import jtid_pkg::*;

   localparam logic [3:0] T_REV = 4'hA;      // arbitrary value
   localparam logic [15:0] T_DEV = 16'h5A3C; // arbitrary value
   localparam logic [10:0] T_MAKER = 11'h2B5; // arbitrary value
   localparam logic [31:0] T_ID = {T_REV, T_DEV, T_MAKER, 1'b1};
   localparam logic [80:0] RST_PINS = {1'b1, {BSR_OUTS{1'b1}}, {BSR_OUTS{1'b0}}};
   localparam logic [159:0] PAT = {32'hC3A51E69, 32'h0F1E2D3C, 32'h96A5B4C3,
                                   32'h1234ABCD, 32'h7E81DB24};

   typedef struct {
      logic [7:0] code;
      int len;
      int mode;
   } jtid_tb_row_t;

   logic sys_clk;
   logic rst_n;
   logic tck;
   jtid_tap_in_t tap;
   logic tdo;
   logic tdo_oe_n;
   logic [BSR_OUTS-1:0] core_out;
   logic [BSR_OUTS-1:0] core_oe_n;
   logic [BSR_LEN-BSR_OUTS-1:0] pin_in;
   logic [BSR_OUTS-1:0] pin_out;
   logic [BSR_OUTS-1:0] pin_oe_n;
   logic [159:0] dout;
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   // mode 0 pins follow core, 1 released, 2 clamped; order matters: clamp after a store
   jtid_tb_row_t rows [7] = '{'{IR_SAMPLE, 113, 0}, '{IR_EXTEST, 113, 0},
      '{IR_CLAMP, 1, 2}, '{IR_HIGHZ, 1, 1}, '{IR_BYPASS, 1, 0},
      '{IR_IDCODE, 32, 0}, '{8'h5A, 1, 0}};

   jtid_tap #(.ID_REV(T_REV), .ID_DEV(T_DEV), .ID_MAKER(T_MAKER)) dut_u (
      .SYS_CLK_I(sys_clk), .RST_N_I(rst_n), .TCK_I(tck), .TAP_I(tap),
      .TDO_O(tdo), .TDO_OE_N_O(tdo_oe_n), .CORE_OUT_I(core_out),
      .CORE_OE_N_I(core_oe_n), .PIN_IN_I(pin_in), .PIN_OUT_O(pin_out),
      .PIN_OE_N_O(pin_oe_n));

   jtid_ctl_model ctl_u (.tck_i(tck), .tdo_i(tdo), .tdo_oe_n_i(tdo_oe_n), .tap_o(tap));

   always #10 sys_clk = ~sys_clk;

   // link clock, phase unrelated to the system clock
   initial begin
      tck = 1'b0;
      #13;
      forever #40 tck = ~tck;
   end

   // ======================================================
   // closing report and hang limit
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_count++;
         final_report();
      end
   end

   // ======================================================
   // main sequence
   initial begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      core_out = '0;
      core_oe_n = '1;
      pin_in = PAT[72:0];
      repeat (12) @(posedge sys_clk);
      #1;
      `CHK(({tdo_oe_n, pin_oe_n, pin_out}), RST_PINS, "reset")
      rst_n = 1'b1;
      @(posedge tck);
      #1;
      ctl_u.step(1'b0);
      ctl_u.scan(1'b0, 160, PAT, dout);
      `CHK(dout[31:0], T_ID, "id after reset")
      for (int r = 0; r < 7; r++) begin
         @(posedge sys_clk);
         #1;
         core_out = PAT[39:0] ^ {8{r[4:0]}};
         core_oe_n = ~core_out;
         ctl_u.scan(1'b1, 8, {152'h0, rows[r].code}, dout);
         `CHK(dout[7:0], IR_CAPTURE_VAL, "ir capture")
         ctl_u.scan(1'b0, 160, PAT, dout);
         `CHK(dout >> rows[r].len, (PAT << rows[r].len) >> rows[r].len, "path")
         if (rows[r].len == 1) begin
            `CHK(dout[0], 1'b0, "bypass capture")
         end else if (rows[r].len == 32) begin
            `CHK(dout[31:0], T_ID, "id word")
         end else begin
            `CHK(dout[112:0], ({core_out, pin_in}), "pin capture")
         end
         repeat (20) @(posedge sys_clk);
         #1;
         if (rows[r].mode == 1) begin
            `CHK(pin_oe_n, {BSR_OUTS{1'b1}}, "released pins")
         end else if (rows[r].mode == 2) begin
            `CHK(pin_out, PAT[159:120], "clamped pins")
         end else begin
            `CHK(({pin_out, pin_oe_n}), ({core_out, core_oe_n}), "pins follow")
         end
      end
      // reserved code still loaded: test-logic-reset must bring the id back
      ctl_u.go_idle();
      ctl_u.scan(1'b0, 160, PAT, dout);
      `CHK(dout[31:0], T_ID, "id after tlr")
      ctl_u.scan(1'b1, 8, {152'h0, IR_BYPASS}, dout);
      @(posedge sys_clk);
      #1;
      rst_n = 1'b0;
      repeat (12) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      @(posedge tck);
      #1;
      ctl_u.step(1'b0);
      ctl_u.scan(1'b0, 160, PAT, dout);
      `CHK(dout[31:0], T_ID, "id after second reset")
      final_report();
   end
endmodule : testbench
